// [design/usf_pkg.sv]
// Constants shared by the unit status flag bank and its synchroniser.
// Assumes one 25 MHz clock and a plain strobe register port.
// Functional notes
// - Unit word bit 20 shows write mode
// - Unit word bit 21 shows RAM differs
// - Unit word bit 25 always reads one
// - Summary bit 0 on memory fault, detail bits
// - Summary bit 1 shows configuration fault
// - Summary bit 3 shows external RAM fault
// - Summary bit 4 from link bits only
// - Summary bit 6 shows link communication error
package usf_pkg;
    // Bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    // Register addresses: area byte above, printed offset below
    localparam logic [15:0] ADDR_UNIT = 16'hc001;
    localparam logic [15:0] ADDR_SUMMARY = 16'hc400;
    localparam logic [15:0] ADDR_DETAIL = 16'hc401;
    localparam logic [15:0] ADDR_IRQ_STAT = 16'hf000;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'hf001;
    // Unit status word fields
    localparam int UNIT_WMODE_BIT = 20;
    localparam int UNIT_RAMDIFF_BIT = 21;
    localparam int UNIT_COMMWR_BIT = 25;
    // Summary word fields
    localparam int SUM_MEM_BIT = 0;
    localparam int SUM_CFG_BIT = 1;
    localparam int SUM_XRAM_BIT = 3;
    localparam int SUM_LINK_BIT = 4;
    localparam int SUM_PLINK_BIT = 6;
    // Memory fault detail fields
    localparam int DET_NV_BIT = 4;
    localparam int DET_SETVAL_BIT = 6;
    localparam int DET_MODEL_BIT = 9;
    localparam int DET_MISMATCH_BIT = 12;
    // Reset values
    localparam logic [15:0] IRQ_STAT_RST = 16'h0000;
    localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    // Positions in the raw flag vector
    localparam int FLG_WMODE = 0;
    localparam int FLG_RAMDIFF = 1;
    localparam int FLG_NV = 2;
    localparam int FLG_SETVAL = 3;
    localparam int FLG_MODEL = 4;
    localparam int FLG_MISMATCH = 5;
    localparam int FLG_CFG = 6;
    localparam int FLG_XRAM = 7;
    localparam int FLG_PLINK = 8;
    localparam int FLG_INTCOMM = 9;
    localparam int FLG_LINK_LO = 10;
    localparam int LINK_N = 8;
    localparam int FLG_N = 18;
endpackage

// [design/usf_flag_if.sv]
// Carries the synchronised status flags from the synchroniser to the bank.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
interface usf_flag_if;
    import usf_pkg::*;
    logic [FLG_N-1:0] flags; // Flags, already in the clock domain
    modport src (output flags);
    modport dst (input flags);
endinterface : usf_flag_if

// [design/usf_sync.sv]
// Two-stage synchroniser for the raw status flags.
// Assumes the flags come from logic outside this clock domain.
`timescale 1ns/1ps
module usf_sync
    import usf_pkg::*;
#(
    parameter int W = FLG_N
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Raw flags
    input wire logic [W-1:0] i_raw,
    // Synchronised flags
    usf_flag_if.src o_sync
);
    // Both stages; first stage is read only by the second
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] safe;
    } usf_sync_t;

    usf_sync_t s_ff; // Registered state
    usf_sync_t nxt_s; // Next state

    // Shift the flags one stage per clock
    always_comb begin
        nxt_s = s_ff;
        nxt_s.meta = i_raw;
        nxt_s.safe = s_ff.meta;
    end

    // Register, cleared by reset so flags start off
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_sync.flags = s_ff.safe;
endmodule : usf_sync

// [design/usf_top.sv]
// Unit status flag bank: read-only status words plus an event interrupt.
// Assumes a plain strobe port master and status levels from other logic.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module usf_top
    import usf_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // Unit state levels
    input wire logic i_write_mode,
    input wire logic i_ram_differs,
    // Memory fault causes
    input wire logic i_nv_err,
    input wire logic i_setval_err,
    input wire logic i_model_data_err,
    input wire logic i_model_mismatch_err,
    // Other fault levels
    input wire logic i_config_err,
    input wire logic i_ext_ram_err,
    input wire logic i_plink_err,
    input wire logic i_int_comm_err,
    input wire logic [LINK_N-1:0] i_link_err_bits,
    // Outputs
    output logic o_int_comm_err,
    output logic o_irq
);
    // All state of the bank
    typedef struct packed {
        logic [WORD_W-1:0] irq_stat; // Sticky event bits
        logic [WORD_W-1:0] irq_mask; // Interrupt enables
        logic [WORD_W-1:0] sum_prev; // Summary one clock back
        logic [DATA_W-1:0] rdata; // Read answer
        logic int_comm; // Separate internal comms status
    } usf_state_t;

    usf_state_t s_ff; // Registered state
    usf_state_t nxt_s; // Next state

    usf_flag_if flag_if (); // Synchronised flags
    logic [FLG_N-1:0] raw; // Gathered raw flags
    logic [FLG_N-1:0] f; // Safe flags

    logic [WORD_W-1:0] summary; // Live summary word
    logic [WORD_W-1:0] detail; // Live memory fault detail
    logic [DATA_W-1:0] unit_word; // Live unit status word
    logic [WORD_W-1:0] events; // Summary bits rising now
    logic [WORD_W-1:0] evt_mask; // Bits that can raise events

    // Gather every outside level into one vector
    always_comb begin
        raw = '0;
        raw[FLG_WMODE] = i_write_mode;
        raw[FLG_RAMDIFF] = i_ram_differs;
        raw[FLG_NV] = i_nv_err;
        raw[FLG_SETVAL] = i_setval_err;
        raw[FLG_MODEL] = i_model_data_err;
        raw[FLG_MISMATCH] = i_model_mismatch_err;
        raw[FLG_CFG] = i_config_err;
        raw[FLG_XRAM] = i_ext_ram_err;
        raw[FLG_PLINK] = i_plink_err;
        raw[FLG_INTCOMM] = i_int_comm_err;
        raw[FLG_LINK_LO +: LINK_N] = i_link_err_bits;
    end

    // Levels come from other logic, so synchronise all of them
    usf_sync #(
        .W(FLG_N)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_raw(raw),
        .o_sync(flag_if.src)
    );

    assign f = flag_if.flags;

    // Build the three status words from the safe flags
    always_comb begin
        detail = '0;
        detail[DET_NV_BIT] = f[FLG_NV];
        detail[DET_SETVAL_BIT] = f[FLG_SETVAL];
        detail[DET_MODEL_BIT] = f[FLG_MODEL];
        detail[DET_MISMATCH_BIT] = f[FLG_MISMATCH];
        summary = '0;
        summary[SUM_MEM_BIT] = |detail;
        summary[SUM_CFG_BIT] = f[FLG_CFG];
        summary[SUM_XRAM_BIT] = f[FLG_XRAM];
        // Only the link bits count here, never the comms status
        summary[SUM_LINK_BIT] = |f[FLG_LINK_LO +: LINK_N];
        summary[SUM_PLINK_BIT] = f[FLG_PLINK];
        // Unused positions stay at the zero set above
        unit_word = '0;
        unit_word[UNIT_WMODE_BIT] = f[FLG_WMODE];
        unit_word[UNIT_RAMDIFF_BIT] = f[FLG_RAMDIFF];
        unit_word[UNIT_COMMWR_BIT] = 1'b1;
    end

    // Only bits that are defined in the summary can raise an event
    always_comb begin
        evt_mask = '0;
        evt_mask[SUM_MEM_BIT] = 1'b1;
        evt_mask[SUM_CFG_BIT] = 1'b1;
        evt_mask[SUM_XRAM_BIT] = 1'b1;
        evt_mask[SUM_LINK_BIT] = 1'b1;
        evt_mask[SUM_PLINK_BIT] = 1'b1;
    end

    assign events = summary & ~s_ff.sum_prev;

    // Next state: register port, sticky events, read answer
    always_comb begin
        nxt_s = s_ff;
        nxt_s.sum_prev = summary;
        // Comms status follows its own input, not the link bits
        nxt_s.int_comm = f[FLG_INTCOMM];
        // Write one to clear
        if (i_wr && i_addr == ADDR_IRQ_STAT) begin
            nxt_s.irq_stat = s_ff.irq_stat & ~i_wdata[WORD_W-1:0];
        end
        // Mask keeps only defined bits
        if (i_wr && i_addr == ADDR_IRQ_MASK) begin
            nxt_s.irq_mask = i_wdata[WORD_W-1:0] & evt_mask;
        end
        // Set after clear so a same-cycle event is never lost
        nxt_s.irq_stat = nxt_s.irq_stat | events;
        // Status words are read-only; writes to them fall through
        nxt_s.rdata = '0;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_UNIT: begin
                    nxt_s.rdata = unit_word;
                end
                ADDR_SUMMARY: begin
                    nxt_s.rdata = {16'h0000, summary};
                end
                ADDR_DETAIL: begin
                    nxt_s.rdata = {16'h0000, detail};
                end
                ADDR_IRQ_STAT: begin
                    nxt_s.rdata = {16'h0000, s_ff.irq_stat};
                end
                ADDR_IRQ_MASK: begin
                    nxt_s.rdata = {16'h0000, s_ff.irq_mask};
                end
                // Unmapped reads answer zero
                default: begin
                    nxt_s.rdata = '0;
                end
            endcase
        end
    end

    // Single register for the whole bank
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_ff.irq_stat <= IRQ_STAT_RST;
            s_ff.irq_mask <= IRQ_MASK_RST;
            s_ff.sum_prev <= '0;
            s_ff.rdata <= RDATA_RST;
            s_ff.int_comm <= 1'b0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs
    assign o_rdata = s_ff.rdata;
    assign o_int_comm_err = s_ff.int_comm;
    assign o_irq = |(s_ff.irq_stat & s_ff.irq_mask);

    // Checks, all on the system clock
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    // Any memory cause, rebuilt here so the check does not reuse detail
    logic mem_any;
    assign mem_any = f[FLG_NV] | f[FLG_SETVAL] | f[FLG_MODEL] |
        f[FLG_MISMATCH];

    // Read requests of each of the three status words
    sequence s_rd_unit;
        i_rd && i_addr == ADDR_UNIT;
    endsequence
    sequence s_rd_sum;
        i_rd && i_addr == ADDR_SUMMARY;
    endsequence
    sequence s_rd_det;
        i_rd && i_addr == ADDR_DETAIL;
    endsequence

    property p_wmode;
        s_rd_unit |=> o_rdata[UNIT_WMODE_BIT] == $past(f[FLG_WMODE]);
    endproperty
    a_wmode: assert property (p_wmode)
        else $error("write mode bit wrong");

    property p_ramdiff;
        s_rd_unit |=> o_rdata[UNIT_RAMDIFF_BIT] == $past(f[FLG_RAMDIFF]);
    endproperty
    a_ramdiff: assert property (p_ramdiff)
        else $error("RAM differs bit wrong");

    property p_commwr;
        s_rd_unit |=> o_rdata[UNIT_COMMWR_BIT];
    endproperty
    a_commwr: assert property (p_commwr)
        else $error("comms write bit not one");

    property p_mem;
        s_rd_sum |=> o_rdata[SUM_MEM_BIT] == $past(mem_any);
    endproperty
    a_mem: assert property (p_mem)
        else $error("memory fault summary wrong");

    property p_cfg;
        s_rd_sum |=> o_rdata[SUM_CFG_BIT] == $past(f[FLG_CFG]);
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("config fault bit wrong");

    property p_xram;
        s_rd_sum |=> o_rdata[SUM_XRAM_BIT] == $past(f[FLG_XRAM]);
    endproperty
    a_xram: assert property (p_xram)
        else $error("external RAM bit wrong");

    property p_link;
        s_rd_sum ##0 (f[FLG_LINK_LO +: LINK_N] != '0)
            |=> o_rdata[SUM_LINK_BIT];
    endproperty
    a_link: assert property (p_link)
        else $error("link summary bit not set");

    property p_intcomm;
        (!f[FLG_INTCOMM] && f[FLG_LINK_LO +: LINK_N] != '0)
            |=> !o_int_comm_err;
    endproperty
    a_intcomm: assert property (p_intcomm)
        else $error("comms status set by link bits");

    property p_plink;
        s_rd_sum |=> o_rdata[SUM_PLINK_BIT] == $past(f[FLG_PLINK]);
    endproperty
    a_plink: assert property (p_plink)
        else $error("link comm error bit wrong");

    property p_unused;
        s_rd_unit |=> (o_rdata & ~(32'h0230_0000)) == '0;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused unit bit not zero");

    property p_sum_unused;
        s_rd_sum |=> o_rdata[31:7] == '0 && !o_rdata[2] && !o_rdata[5];
    endproperty
    a_sum_unused: assert property (p_sum_unused)
        else $error("unused summary bit not zero");

    property p_detail;
        s_rd_det |=> o_rdata[DET_NV_BIT] == $past(f[FLG_NV]) &&
            o_rdata[DET_SETVAL_BIT] == $past(f[FLG_SETVAL]) &&
            o_rdata[DET_MODEL_BIT] == $past(f[FLG_MODEL]) &&
            o_rdata[DET_MISMATCH_BIT] == $past(f[FLG_MISMATCH]);
    endproperty
    a_detail: assert property (p_detail)
        else $error("memory fault detail bit wrong");

    property p_det_unused;
        s_rd_det |=> (o_rdata & ~(32'h0000_1250)) == '0;
    endproperty
    a_det_unused: assert property (p_det_unused)
        else $error("unused detail bit not zero");

    // Without a read the answer port rests at zero
    property p_rd_idle;
        !i_rd |=> o_rdata == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero when idle");

    // Comms status tracks only its own input, one clock on
    property p_intcomm_follow;
        1'b1 |=> o_int_comm_err == $past(f[FLG_INTCOMM]);
    endproperty
    a_intcomm_follow: assert property (p_intcomm_follow)
        else $error("comms status does not follow its input");

    // A masked-in rising fault must raise the line one clock later
    sequence s_evt;
        (events & s_ff.irq_mask) != '0;
    endsequence
    property p_irq;
        s_evt |=> o_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("event did not raise interrupt");

    // An event beside a clear of the same bit must still leave it set
    property p_set_wins;
        (events != '0) |=> (s_ff.irq_stat & $past(events)) == $past(events);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost to a clear");

    // Undefined bits can never be enabled
    property p_mask_defined;
        (s_ff.irq_mask & ~evt_mask) == '0;
    endproperty
    a_mask_defined: assert property (p_mask_defined)
        else $error("undefined mask bit set");
endmodule : usf_top

// [test/tb.sv]
// Self-checking bench for the unit status flag bank top module.
// Assumes the package is visible; one 25 MHz clock, no partner.
`timescale 1ns/1ps
module tb;
    import usf_pkg::*;
    // One table row: flag inputs beside the words they should give
    typedef struct packed {
        logic [17:0] flags;
        logic [31:0] unit;
        logic [15:0] sum;
        logic [15:0] det;
    } usf_row_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [17:0] flg = '0; // Flag inputs, packed in bench order
    logic int_comm_err;
    logic irq;
    int miscompares = 0;
    int total_checks = 0;
    logic [31:0] got; // Word returned by the last read
    usf_row_t rows [12];

    // Design under test; every input driven from the bench
    usf_top u_usf_top (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_write_mode(flg[0]), .i_ram_differs(flg[1]),
        .i_nv_err(flg[2]), .i_setval_err(flg[3]),
        .i_model_data_err(flg[4]), .i_model_mismatch_err(flg[5]),
        .i_config_err(flg[6]), .i_ext_ram_err(flg[7]),
        .i_plink_err(flg[8]), .i_int_comm_err(flg[9]),
        .i_link_err_bits(flg[17:10]),
        .o_int_comm_err(int_comm_err), .o_irq(irq)
    );

    // 40 ns clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // Compare and count; case equality so unknowns never match
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Single-cycle write strobe
    task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    // Single-cycle read; data stands only the cycle after the strobe
    task automatic reg_rd(input logic [15:0] a);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask

    // Apply flags, then let the two-flop synchroniser settle
    task automatic set_flags(input logic [17:0] v);
        @(posedge sys_clk);
        flg <= v;
        repeat (4) @(posedge sys_clk);
    endtask

    // Verdict; the only place the run ends
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog sized well beyond the expected run of a few hundred cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        end_of_test();
    end

    // Main sequence
    initial begin
        // Ordinary cases: one source at a time
        rows[0] = '{18'h00000, 32'h0200_0000, 16'h0000, 16'h0000};
        rows[1] = '{18'h00001, 32'h0210_0000, 16'h0000, 16'h0000};
        rows[2] = '{18'h00002, 32'h0220_0000, 16'h0000, 16'h0000};
        rows[3] = '{18'h00004, 32'h0200_0000, 16'h0001, 16'h0010};
        rows[4] = '{18'h00008, 32'h0200_0000, 16'h0001, 16'h0040};
        rows[5] = '{18'h00010, 32'h0200_0000, 16'h0001, 16'h0200};
        rows[6] = '{18'h00020, 32'h0200_0000, 16'h0001, 16'h1000};
        rows[7] = '{18'h00040, 32'h0200_0000, 16'h0002, 16'h0000};
        rows[8] = '{18'h00080, 32'h0200_0000, 16'h0008, 16'h0000};
        rows[9] = '{18'h00100, 32'h0200_0000, 16'h0040, 16'h0000};
        rows[10] = '{18'h20000, 32'h0200_0000, 16'h0010, 16'h0000};
        rows[11] = '{18'h00200, 32'h0200_0000, 16'h0000, 16'h0000};
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            set_flags(rows[i].flags);
            reg_rd(ADDR_UNIT);
            chk("unit", rows[i].unit, got);
            reg_rd(ADDR_SUMMARY);
            chk("sum", {16'h0, rows[i].sum}, got);
            reg_rd(ADDR_DETAIL);
            chk("detail", {16'h0000, rows[i].det}, got);
            chk("int_comm", 32'(rows[i].flags[9]), 32'(int_comm_err));
        end
        $display("Table test done");
        // Writes to read-only words are ignored; unmapped reads give 0
        set_flags(18'h3ffff);
        reg_wr(ADDR_SUMMARY, 32'h0000_0000);
        reg_wr(ADDR_UNIT, 32'h0000_0000);
        reg_rd(ADDR_SUMMARY);
        chk("summary_all", 32'h5b, got);
        reg_rd(ADDR_UNIT);
        chk("unit_all", 32'h0230_0000, got);
        reg_rd(ADDR_DETAIL);
        chk("detail_all", 32'h0000_1250, got);
        reg_rd(16'hc402);
        chk("unmapped", 32'h0000_0000, got);
        // Back-to-back reads: unit then summary
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= ADDR_UNIT;
        @(posedge sys_clk);
        addr <= ADDR_SUMMARY;
        #1 chk("b2b_unit", 32'h0230_0000, rdata);
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 chk("b2b_sum", 32'h0000_005b, rdata);
        $display("Read-only test done");
        // Interrupt: clear, mask, raise, acknowledge
        set_flags(18'h00000);
        reg_wr(ADDR_IRQ_STAT, 32'h0000_ffff);
        reg_rd(ADDR_IRQ_STAT);
        chk("irq_stat_clr", 32'h0000_0000, got);
        reg_wr(ADDR_IRQ_MASK, 32'hffff_ffff);
        reg_rd(ADDR_IRQ_MASK);
        chk("irq_mask", 32'h0000_005b, got);
        chk("irq_idle", 32'h0, {31'h0, irq});
        set_flags(18'h00040);
        chk("irq_set", 32'h1, {31'h0, irq});
        reg_rd(ADDR_IRQ_STAT);
        chk("irq_stat_cfg", 32'h0000_0002, got);
        reg_wr(ADDR_IRQ_STAT, 32'h0000_0002);
        repeat (2) @(posedge sys_clk);
        chk("irq_ack", 32'h0, {31'h0, irq});
        // Masked event sets status but keeps the line low
        reg_wr(ADDR_IRQ_MASK, 32'h0000_0000);
        set_flags(18'h00080);
        reg_rd(ADDR_IRQ_STAT);
        chk("irq_stat_xram", 32'h0000_0008, got);
        chk("irq_masked", 32'h0, {31'h0, irq});
        $display("Interrupt test done");
        // Second reset mid-run with faults present
        reg_wr(ADDR_IRQ_MASK, 32'h0000_ffff);
        @(posedge sys_clk);
        rst <= 1'b1;
        flg <= 18'h00200;
        repeat (3) @(posedge sys_clk);
        #1 chk("rst_rdata", 32'h0, rdata);
        chk("rst_irq", 32'h0, {31'h0, irq});
        chk("rst_intcomm", 32'h0, {31'h0, int_comm_err});
        @(posedge sys_clk);
        rst <= 1'b0;
        // First edge after release: outputs still at rest
        @(posedge sys_clk);
        #1 chk("rel_rdata", 32'h0, rdata);
        chk("rel_irq", 32'h0, {31'h0, irq});
        chk("rel_intcomm", 32'h0, {31'h0, int_comm_err});
        reg_rd(ADDR_IRQ_MASK);
        chk("rst_mask", 32'h0000_0000, got);
        // Comms input held through reset shows three clocks after release
        chk("rel_intcomm_on", 32'h1, {31'h0, int_comm_err});
        $display("Reset test done");
        end_of_test();
    end
endmodule // tb
